// ==== uwtb_regs.vh ====
// constants for the serial port with timer-driven bit rate
`ifndef UWTB_REGS_VH
`define UWTB_REGS_VH
`define UWTB_CLK_HZ 10000000
`define UWTB_SRC_CORE 3'h0
`define UWTB_SRC_DIV4 3'h1
`define UWTB_SRC_DIV12 3'h2
`define UWTB_SRC_DIV48 3'h3
`define UWTB_SRC_XOSC8 3'h4
`define UWTB_SRC_EXT 3'h5
`define UWTB_DIV4 6'h03
`define UWTB_DIV12 6'h0B
`define UWTB_DIV48 6'h2F
`define UWTB_XDIV8 3'h7
`define UWTB_RELOAD_RST 8'h00
`define UWTB_BITS_MODE1 4'h8
`define UWTB_BITS_MODE3 4'h9
`endif

// ==== uwtb_prescale.v ====
// timer one clock source selection, producing a one-cycle tick
`timescale 1ns/1ns
`include "uwtb_regs.vh"
module uwtb_prescale (
  input wire clk,
  input wire arst_n,
  input wire [2:0] clk_sel,
  input wire xosc_rise,
  input wire ext_fall,
  output reg tick
);
  reg [5:0] div_cnt_ff;
  reg [2:0] xdiv_cnt_ff;

  // free-running divider; taps give /4, /12 and /48
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 6'h00;
      xdiv_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= (div_cnt_ff == `UWTB_DIV48) ? 6'h00 : div_cnt_ff + 6'h01;
      if (xosc_rise)
        xdiv_cnt_ff <= xdiv_cnt_ff + 3'h1;
    end
  end

  // pick one of six sources
  always @* begin
    case (clk_sel)
      `UWTB_SRC_CORE: tick = 1'b1;
      `UWTB_SRC_DIV4: tick = (div_cnt_ff[1:0] == 2'h3);
      `UWTB_SRC_DIV12: tick = (div_cnt_ff == `UWTB_DIV12) || (div_cnt_ff == 6'h17) ||
                              (div_cnt_ff == 6'h23) || (div_cnt_ff == `UWTB_DIV48);
      `UWTB_SRC_DIV48: tick = (div_cnt_ff == `UWTB_DIV48);
      `UWTB_SRC_XOSC8: tick = xosc_rise && (xdiv_cnt_ff == `UWTB_XDIV8);
      `UWTB_SRC_EXT: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end
endmodule // uwtb_prescale

// ==== uwtb_reload_timer.v ====
// 8-bit auto-reload counter with halved overflow output
`timescale 1ns/1ns
module uwtb_reload_timer (
  input wire clk,
  input wire arst_n,
  input wire run,
  input wire tick,
  input wire [7:0] reload,
  input wire force_load,
  output reg [7:0] count,
  output reg bit_tick
);
  reg half_ff;

  // count up on each tick while run is high, reload on overflow or on demand
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 8'h00;
      half_ff <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      // a forced reload primes the halver, so the first bit tick comes half a bit
      // later and every sample after it lands mid-bit rather than on an edge
      if (force_load) begin
        count <= reload;
        half_ff <= 1'b1;
      end else if (run && tick) begin
        if (count == 8'hFF) begin
          count <= reload; // rate = tick / (256 - reload)
          half_ff <= ~half_ff;
          bit_tick <= half_ff; // every second overflow
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule // uwtb_reload_timer

// ==== uwtb_uart.v ====
// serial port with timer one bit-rate generation, top level
`timescale 1ns/1ns
`include "uwtb_regs.vh"
module uwtb_uart (
  input wire clk,
  input wire arst_n,
  input wire serial_rx,
  output reg serial_tx,
  input wire timer_one_ext_input,
  input wire xosc_clk,
  input wire timer_one_run,
  input wire [2:0] timer_one_clk_sel,
  input wire [7:0] timer_one_reload_byte,
  output wire [7:0] timer_one_low_count,
  input wire mode3_sel,
  input wire rx_enable,
  input wire tx_bit8,
  output reg rx_bit8,
  input wire serial_irq_en,
  input wire serial_data_buffer_wr,
  input wire [7:0] serial_data_buffer_wdata,
  input wire serial_data_buffer_rd,
  output reg [7:0] serial_data_buffer_rdata,
  input wire tx_done_clr,
  input wire rx_done_clr,
  output reg tx_done_flag,
  output reg rx_done_flag,
  output wire tx_busy,
  output wire serial_irq
);
  // receiver states
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  reg [1:0] rx_sync_ff;
  reg rx_s_ff;
  reg [1:0] ext_sync_ff;
  reg ext_s_ff;
  reg [1:0] xosc_sync_ff;
  reg xosc_s_ff;
  wire t1_tick;
  wire tx_bit_tick;
  wire rx_bit_tick;
  wire rx_fall;
  wire [7:0] rx_copy_count;
  reg rx_force_ff;

  reg [9:0] tx_shift_ff;
  reg [3:0] tx_left_ff;
  reg tx_pend_ff;
  reg [8:0] tx_load_ff;

  reg [1:0] rx_state_ff;
  reg [1:0] nxt_rx_state;
  reg [8:0] rx_shift_ff;
  reg [3:0] rx_cnt_ff;
  reg rx_half_ff;

  // frame length in data bits for the selected mode
  function [3:0] data_bits;
    input m3;
    begin
      data_bits = m3 ? `UWTB_BITS_MODE3 : `UWTB_BITS_MODE1;
    end
  endfunction

  // two-stage synchronisers for every pin input
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync_ff <= 2'h3;
      rx_s_ff <= 1'b1;
      ext_sync_ff <= 2'h3;
      ext_s_ff <= 1'b1;
      xosc_sync_ff <= 2'h0;
      xosc_s_ff <= 1'b0;
    end else begin
      rx_sync_ff <= {rx_sync_ff[0], serial_rx};
      rx_s_ff <= rx_sync_ff[1];
      ext_sync_ff <= {ext_sync_ff[0], timer_one_ext_input};
      ext_s_ff <= ext_sync_ff[1];
      xosc_sync_ff <= {xosc_sync_ff[0], xosc_clk};
      xosc_s_ff <= xosc_sync_ff[1];
    end
  end

  // edges seen only past the second synchroniser stage
  assign rx_fall = rx_s_ff & ~rx_sync_ff[1];

  uwtb_prescale u_prescale (
    .clk(clk),
    .arst_n(arst_n),
    .clk_sel(timer_one_clk_sel),
    .xosc_rise(xosc_sync_ff[1] & ~xosc_s_ff),
    .ext_fall(ext_s_ff & ~ext_sync_ff[1]),
    .tick(t1_tick)
  );

  // visible low count drives the transmitter
  uwtb_reload_timer u_tx_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(timer_one_run),
    .tick(t1_tick),
    .reload(timer_one_reload_byte),
    .force_load(1'b0),
    .count(timer_one_low_count),
    .bit_tick(tx_bit_tick)
  );

  // hidden copy for receive, same reload and run enable
  uwtb_reload_timer u_rx_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(timer_one_run),
    .tick(t1_tick),
    .reload(timer_one_reload_byte),
    .force_load(rx_force_ff),
    .count(rx_copy_count),
    .bit_tick(rx_bit_tick)
  );

  // transmitter: a write queues a frame, launched on the first bit tick after it with no frame in progress
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_shift_ff <= 10'h3FF;
      tx_left_ff <= 4'h0;
      tx_pend_ff <= 1'b0;
      tx_load_ff <= 9'h000;
      serial_tx <= 1'b1;
    end else begin
      if (serial_data_buffer_wr) begin
        tx_pend_ff <= 1'b1;
        tx_load_ff <= {tx_bit8, serial_data_buffer_wdata};
      end
      if (tx_bit_tick) begin
        if (tx_left_ff != 4'h0) begin
          serial_tx <= tx_shift_ff[0]; // lsb first
          tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
          tx_left_ff <= tx_left_ff - 4'h1;
        end else if (tx_pend_ff && !serial_data_buffer_wr) begin
          serial_tx <= 1'b0; // start bit
          tx_shift_ff <= mode3_sel ? {1'b1, tx_load_ff} : {2'h3, tx_load_ff[7:0]};
          tx_left_ff <= data_bits(mode3_sel) + 4'h1; // data plus stop
          tx_pend_ff <= 1'b0;
        end else begin
          serial_tx <= 1'b1; // idle high
        end
      end
    end
  end

  assign tx_busy = tx_pend_ff | (tx_left_ff != 4'h0);

  // receiver next-state; half-bit sample point uses alternate timer overflows
  always @* begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      RX_IDLE: if (rx_fall && rx_enable && timer_one_run) nxt_rx_state = RX_START;
      RX_START: if (rx_bit_tick) nxt_rx_state = rx_s_ff ? RX_IDLE : RX_DATA;
      RX_DATA: if (rx_bit_tick && rx_cnt_ff == 4'h1) nxt_rx_state = RX_STOP;
      RX_STOP: if (rx_bit_tick) nxt_rx_state = RX_IDLE;
      default: nxt_rx_state = RX_IDLE;
    endcase
  end

  // receiver datapath; runs while transmitter is busy
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_shift_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_half_ff <= 1'b0;
      rx_force_ff <= 1'b0;
      serial_data_buffer_rdata <= 8'h00;
      rx_bit8 <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_force_ff <= (rx_state_ff == RX_IDLE) && rx_fall;
      rx_half_ff <= 1'b0;
      if (nxt_rx_state == RX_DATA && rx_state_ff == RX_START)
        rx_cnt_ff <= data_bits(mode3_sel);
      if (rx_state_ff == RX_DATA && rx_bit_tick) begin
        rx_shift_ff <= mode3_sel ? {rx_s_ff, rx_shift_ff[8:1]} :
                                   {1'b0, rx_s_ff, rx_shift_ff[7:1]};
        rx_cnt_ff <= rx_cnt_ff - 4'h1;
      end
      // stop bit high: move byte to buffer, shifter free at once
      if (rx_state_ff == RX_STOP && rx_bit_tick && rx_s_ff) begin
        serial_data_buffer_rdata <= rx_shift_ff[7:0];
        rx_bit8 <= mode3_sel ? rx_shift_ff[8] : rx_s_ff;
        rx_half_ff <= 1'b1;
      end
    end
  end

  // done flags: hardware set wins over a software clear in the same cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      if (tx_bit_tick && tx_left_ff == 4'h1)
        tx_done_flag <= 1'b1;
      else if (tx_done_clr)
        tx_done_flag <= 1'b0;
      if (rx_half_ff)
        rx_done_flag <= 1'b1;
      else if (rx_done_clr)
        rx_done_flag <= 1'b0;
    end
  end

  // read strobe has no side effect; flags stay until cleared
  assign serial_irq = serial_irq_en & (tx_done_flag | rx_done_flag);
endmodule // uwtb_uart

// ==== uwtb_chk.sv ====
// assertion checker for the timer-clocked serial port
`timescale 1ns/1ns
module uwtb_chk (
  input logic clk,
  input logic arst_n,
  input logic serial_tx,
  input logic tx_busy,
  input logic serial_irq,
  input logic serial_irq_en,
  input logic tx_done_flag,
  input logic rx_done_flag,
  input logic tx_done_clr,
  input logic rx_done_clr,
  input logic serial_data_buffer_wr,
  input logic [7:0] serial_data_buffer_rdata,
  input logic timer_one_run,
  input logic [7:0] timer_one_low_count,
  input logic [7:0] timer_one_reload_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // line rests high outside frames, stop bit high when the flag rises
  a_tx_idle_high: assert property (!tx_busy |-> serial_tx)
    else $error("tx line low while idle");
  a_stop_bit_high: assert property ($rose(tx_done_flag) |-> serial_tx)
    else $error("tx flag rose without stop level");
  a_irq_from_flags: assert property (serial_irq == (serial_irq_en && (tx_done_flag || rx_done_flag)))
    else $error("irq does not follow flags");
  // flags only drop on a software clear
  a_tx_flag_sticky: assert property (tx_done_flag && !tx_done_clr |=> tx_done_flag)
    else $error("tx flag dropped by hardware");
  a_rx_flag_sticky: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
    else $error("rx flag dropped by hardware");
  a_write_starts_tx: assert property (serial_data_buffer_wr |=> tx_busy)
    else $error("write did not start transmit");
  a_rdata_with_flag: assert property ($changed(serial_data_buffer_rdata) |-> ##[0:2] rx_done_flag)
    else $error("receive byte changed without flag");
  // counter frozen while stopped, otherwise steps or reloads
  a_count_frozen: assert property (!timer_one_run |=> $stable(timer_one_low_count))
    else $error("counter moved while stopped");
  a_count_step: assert property ($changed(timer_one_low_count) |->
    timer_one_low_count == $past(timer_one_low_count) + 8'h01 ||
    timer_one_low_count == $past(timer_one_reload_byte) ||
    timer_one_low_count == timer_one_reload_byte)
    else $error("counter jumped");
endmodule // uwtb_chk

bind uwtb_uart uwtb_chk u_chk (.*);

// ==== uwtb_peer.sv ====
// far-end serial transceiver model
`timescale 1ns/1ns
module uwtb_peer #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic serial_tx,
  input wire logic [3:0] nbits,
  output logic serial_rx
);
  logic [8:0] got;
  int got_n = 0;
  initial serial_rx = 1'b1;
  // low start, lsb first, high stop; line back high afterwards
  task automatic send(input logic [8:0] d);
    serial_rx = 1'b0;
    repeat (BIT) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      serial_rx = d[i];
      repeat (BIT) @(negedge clk);
    end
    serial_rx = 1'b1;
    repeat (BIT) @(negedge clk);
  endtask
  // mid-bit sampling tolerates small phase error of the sender
  always @(negedge serial_tx) begin
    got = 9'h000;
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(negedge clk);
      got[i] = serial_tx;
    end
    got_n++;
  end
endmodule // uwtb_peer

// ==== testbench.sv ====
// self-checking bench for the timer-clocked serial port
`timescale 1ns/1ns
module testbench;
  localparam int BIT = 32;
  logic clk = 1'b0, arst_n = 1'b0, serial_rx, serial_tx, timer_one_ext_input = 1'b1;
  logic xosc_clk = 1'b0, timer_one_run = 1'b0, mode3_sel = 1'b0, rx_enable = 1'b1;
  logic tx_bit8 = 1'b0, rx_bit8, serial_irq_en = 1'b0, serial_data_buffer_wr = 1'b0;
  logic serial_data_buffer_rd = 1'b0, tx_done_clr = 1'b0, rx_done_clr = 1'b0;
  logic tx_done_flag, rx_done_flag, tx_busy, serial_irq;
  logic [2:0] timer_one_clk_sel = 3'h0;
  logic [7:0] timer_one_reload_byte = 8'h00, timer_one_low_count;
  logic [7:0] serial_data_buffer_wdata = 8'h00, serial_data_buffer_rdata;
  int errors = 0, comparisons = 0;
  uwtb_uart u_uwtb_uart (.*);
  uwtb_peer #(.BIT(BIT)) u_peer (.clk(clk), .serial_tx(serial_tx),
    .nbits(mode3_sel ? 4'h9 : 4'h8), .serial_rx(serial_rx));
  // clocks; source pins toggle on falling edges only
  always #50 clk = ~clk;
  always #200 xosc_clk = ~xosc_clk;
  always #300 timer_one_ext_input = ~timer_one_ext_input;
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cycles between counter steps for one clock source
  task automatic t_src(input logic [2:0] s, input int d);
    logic [7:0] c;
    int n;
    timer_one_clk_sel = s;
    repeat (200) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      c = timer_one_low_count;
      for (n = 0; n < 400 && timer_one_low_count == c; n++) @(negedge clk);
    end
    chk_val(9'(n), 9'(d));
    $display("source %0d done", s);
  endtask
  task automatic t_tx(input logic [8:0] d, input logic m);
    int n;
    mode3_sel = m;
    tx_bit8 = d[8];
    serial_data_buffer_wdata = d[7:0];
    serial_data_buffer_wr = 1'b1;
    @(negedge clk);
    serial_data_buffer_wr = 1'b0;
    n = u_peer.got_n;
    chk_bit(tx_busy, 1'b1);
    for (int i = 0; i < 20 * BIT && !tx_done_flag; i++) @(negedge clk);
    chk_bit(tx_done_flag, 1'b1);
    chk_bit(serial_irq, serial_irq_en);
    repeat (BIT) @(negedge clk);
    chk_val(9'(u_peer.got_n - n), 9'h001);
    chk_val(u_peer.got, m ? d : {1'b0, d[7:0]});
    chk_bit(tx_done_flag, 1'b1);
    tx_done_clr = 1'b1;
    @(negedge clk);
    tx_done_clr = 1'b0;
    @(negedge clk);
    chk_bit(tx_done_flag, 1'b0);
    $display("transmit %h done", d);
  endtask
  task automatic t_rx(input logic [8:0] d, input logic m, input logic clr);
    mode3_sel = m;
    u_peer.send(d);
    for (int i = 0; i < 4 * BIT && !rx_done_flag; i++) @(negedge clk);
    chk_bit(rx_done_flag, 1'b1);
    chk_bit(serial_irq, serial_irq_en);
    chk_val({rx_bit8, serial_data_buffer_rdata}, {m ? d[8] : 1'b1, d[7:0]});
    rx_done_clr = clr;
    @(negedge clk);
    rx_done_clr = 1'b0;
    @(negedge clk);
    chk_bit(rx_done_flag, !clr);
    $display("receive %h done", d);
  endtask
  // second byte arrives and a transmit runs after a read strobe of the first, its flag still set
  task automatic t_dup();
    t_rx(9'h03C, 1'b0, 1'b0);
    fork
      u_peer.send(9'h0E1);
    join_none
    repeat (5 * BIT) @(negedge clk);
    serial_data_buffer_rd = 1'b1;
    @(negedge clk);
    serial_data_buffer_rd = 1'b0;
    chk_val(serial_data_buffer_rdata, 9'h03C);
    t_tx(9'h099, 1'b0);
    chk_val(serial_data_buffer_rdata, 9'h0E1);
    $display("duplex done");
  endtask
  // receiver disabled, then timer stopped: no reception, counter frozen
  task automatic t_off();
    logic [7:0] c;
    rx_done_clr = 1'b1;
    @(negedge clk);
    rx_done_clr = 1'b0;
    rx_enable = 1'b0;
    u_peer.send(9'h0F0);
    repeat (BIT) @(negedge clk);
    chk_bit(rx_done_flag, 1'b0);
    chk_val(serial_data_buffer_rdata, 9'h0E1);
    rx_enable = 1'b1;
    timer_one_run = 1'b0;
    c = timer_one_low_count;
    u_peer.send(9'h00F);
    repeat (BIT) @(negedge clk);
    chk_val(timer_one_low_count, c);
    chk_bit(rx_done_flag, 1'b0);
    timer_one_run = 1'b1;
    $display("disabled paths done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    chk_val({serial_tx, tx_done_flag, rx_done_flag, serial_irq, tx_busy}, 9'h010);
    chk_val(timer_one_low_count, 9'h000);
    timer_one_run = 1'b1;
    t_src(3'h0, 1);
    t_src(3'h1, 4);
    t_src(3'h2, 12);
    t_src(3'h3, 48);
    t_src(3'h4, 32);
    t_src(3'h5, 6);
    timer_one_clk_sel = 3'h0;
    timer_one_reload_byte = 8'hF0; // 16 clocks per overflow, two per bit
    t_tx(9'h0A5, 1'b0);
    t_tx(9'h13C, 1'b1);
    serial_irq_en = 1'b1;
    t_rx(9'h05A, 1'b0, 1'b1);
    t_rx(9'h1C3, 1'b1, 1'b1);
    t_dup();
    t_off();
    end_of_test();
  end
  // watchdog sized well above the expected run of about 4300 cycles
  initial begin
    #4000000;
    errors++;
    end_of_test();
  end
endmodule // testbench
